// *** bench/pfh_flash_model.sv ***
// pfh_flash_model: behavioural nor flash behind the host pins
// assumes pfh_host pins; data lines have no pull, so undriven lines show inverted last value
`timescale 1ns/1ps
module pfh_flash_model
  import pfh_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic       FACTORY    = 1'b1
)(
  // clock
  input  wire logic              clk,
  // host pins
  input  wire pfh_ctl_t          ctl,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              as_hv,
  input  wire logic [1:0]        prot,
  input  wire logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0]      dq_i,
  output logic                   rdy
);
  logic [15:0]       mem [128];
  logic [15:0]       last = 16'h0000;
  logic [ADDR_W-1:0] wa;
  logic [2:0]        busy = 3'h0;
  logic [7:0]        asv;
  logic [15:0]       rd;
  logic [15:0]       m;
  // drive only when active and enabled
  wire drv = ctl.clr_n & ~ctl.sel_n & ~ctl.oe_n;
  wire wok = ctl.clr_n & ~ctl.sel_n & ctl.oe_n;
  wire lock = (addr[20:12] == 9'h000) && (prot == 2'h0);
  assign asv = (addr[1:0] == 2'h0) ? MAKER_CODE : (addr[1:0] == 2'h2) ? {7'h00, lock} :
               (addr[1:0] == 2'h3) ? (FACTORY ? 8'h99 : 8'h19) : 8'h00;
  assign m  = mem[addr[6:0]];
  assign rd = as_hv ? {8'h00, asv} : ctl.width_word ? m : {8'h00, dq_o[15] ? m[15:8] : m[7:0]};
  // upper lines float in byte mode
  assign dq_i[7:0]  = drv ? rd[7:0] : ~last[7:0];
  assign dq_i[15:8] = (drv & ctl.width_word) ? rd[15:8] : ~last[15:8];
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  always @(posedge clk) if (drv) last <= dq_i;
  always @(negedge ctl.we_n) if (wok) wa <= addr;
  // data on strobe rise, outer boot refused when locked
  always @(posedge ctl.we_n) begin
    if (wok && !(wa[20:12] == 9'h000 && prot == 2'h0)) begin
      if (ctl.width_word) mem[wa[6:0]] <= dq_o;
      else if (dq_o[15]) mem[wa[6:0]][15:8] <= dq_o[7:0];
      else mem[wa[6:0]][7:0] <= dq_o[7:0];
    end
  end
  // busy while clear low and a short recovery after
  always @(posedge clk) busy <= !ctl.clr_n ? 3'h4 : (busy != 3'h0) ? busy - 3'h1 : busy;
  assign rdy = (busy == 3'h0);
endmodule

// *** bench/pfh_host_tb.sv ***
// pfh_host_tb: directed bench for pfh_host against the flash model
// assumes 20 MHz clock; inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module pfh_host_tb
  import pfh_pkg::*;
;
  logic clk, arst_n, req_valid, hv_clear, req_ready, rsp_valid, locked, factory, as_hv, clr_hv, rb;
  pfh_req_t          req;
  pfh_prot_t         prot_mode;
  pfh_ctl_t          ctl;
  logic [DATA_W-1:0] rsp_data, dq_o, dq_oe_n, dq_i;
  logic [ADDR_W-1:0] fl_addr;
  logic [1:0]        fl_pa;
  int                errors = 0;
  int                checks = 0;
  pfh_host pfh_host_i (.CLK_SYS(clk), .ARST_N(arst_n), .REQ_VALID(req_valid), .REQ(req),
    .PROT_MODE(prot_mode), .HV_CLEAR(hv_clear), .CTL_OUT(ctl), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_LOCKED(locked), .RSP_FACTORY(factory),
    .FL_ADDR(fl_addr), .FL_AUTOSEL_HV(as_hv), .FL_PROTECT_ACCEL(fl_pa), .FL_CLR_HV(clr_hv),
    .FL_DQ_O(dq_o), .FL_DQ_OE_N(dq_oe_n), .FL_DQ_I(dq_i), .FL_READY_BUSY(rb));
  pfh_flash_model pfh_flash_model_i (.clk(clk), .ctl(ctl), .addr(fl_addr), .as_hv(as_hv),
    .prot(fl_pa), .dq_o(dq_o), .dq_i(dq_i), .rdy(rb));
  task automatic stop_test();
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one request: wait idle, hold valid over the taking edge
  task automatic go(input pfh_op_t op, input logic [20:0] a, input logic [15:0] d, input logic w);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 60);
    chk("req_ready", 16'h0001, {15'h0, req_ready});
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, a, d, w};
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input pfh_op_t op, input logic [20:0] a, input logic w, input logic [15:0] e);
    int n;
    go(op, a, 16'h0000, w);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 60);
    chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    chk("rsp_data", e, rsp_data);
  endtask
  task automatic set_prot(input pfh_prot_t p);
    @(posedge clk);
    prot_mode <= p;
    repeat (2) @(negedge clk);
    chk("protect_pin", {14'h0, p}, {14'h0, fl_pa});
  endtask
  task automatic t_word();
    set_prot(PFH_PROT_KEEP);
    go(PFH_OP_WRITE, 21'h00_1005, 16'hA55A, 1'b1);
    rd(PFH_OP_READ, 21'h00_1005, 1'b1, 16'hA55A);
  endtask
  task automatic t_byte();
    go(PFH_OP_WRITE, 21'h00_101B, 16'h003C, 1'b0);
    repeat (2) @(negedge clk);
    chk("byte_lsb_pin", 16'h0001, {15'h0, dq_o[15]});
    rd(PFH_OP_READ, 21'h00_101B, 1'b0, 16'h003C);
  endtask
  task automatic t_prot();
    set_prot(PFH_PROT_LOCK);
    go(PFH_OP_WRITE, 21'h00_0010, 16'h1234, 1'b1);
    rd(PFH_OP_READ, 21'h00_0010, 1'b1, 16'hFFFF);
    rd(PFH_OP_AUTOSEL, 21'h00_0002, 1'b1, 16'h0001);
    chk("locked", 16'h0001, {15'h0, locked});
    set_prot(PFH_PROT_ACCEL);
    rd(PFH_OP_AUTOSEL, 21'h00_0002, 1'b1, 16'h0000);
    go(PFH_OP_WRITE, 21'h00_0010, 16'h1234, 1'b1);
    rd(PFH_OP_READ, 21'h00_0010, 1'b1, 16'h1234);
  endtask
  task automatic t_auto();
    rd(PFH_OP_AUTOSEL, 21'h00_0003, 1'b1, 16'h0099);
    chk("factory", 16'h0001, {15'h0, factory});
    rd(PFH_OP_AUTOSEL, 21'h00_0000, 1'b1, 16'h005A);
  endtask
  task automatic t_clear();
    @(posedge clk);
    hv_clear <= 1'b1;
    repeat (2) @(negedge clk);
    chk("clear_hv", 16'h0001, {15'h0, clr_hv});
    rd(PFH_OP_CLEAR, 21'h00_0000, 1'b1, 16'h005A);
    chk("ready_busy", 16'h0001, {15'h0, rb});
    rd(PFH_OP_READ, 21'h00_1005, 1'b1, 16'hA55A);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2_000_000;
    errors++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    prot_mode = PFH_PROT_KEEP;
    hv_clear = 1'b0;
    repeat (5) @(posedge clk);
    chk("reset_clear", 16'h0000, {15'h0, ctl.clr_n});
    chk("reset_dq_oe", 16'hFFFF, dq_oe_n);
    arst_n <= 1'b1;
    t_word();
    t_byte();
    t_prot();
    t_auto();
    t_clear();
    stop_test();
  end
endmodule

// *** shared/pfh_pkg.sv ***
// pfh_pkg: constants, enums and carrier structs for the parallel flash host controller
// assumes a 20 MHz system clock; flash pins are driven as plain logic levels
package pfh_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLR_PULSE_NS  = 500;
  localparam int unsigned ACCESS_NS     = 90;
  localparam int unsigned WE_LOW_NS     = 35;
  localparam int unsigned WE_HIGH_NS    = 30;
  localparam int unsigned CLR_PULSE_CYC = (CLR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ACCESS_CYC    = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WE_LOW_CYC    = (WE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WE_HIGH_CYC   = (WE_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ADDR_W        = 21;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CNT_W         = 8;
  // autoselect selector bits
  localparam int unsigned SEL_A6        = 6;
  localparam int unsigned SEL_A1        = 1;
  localparam int unsigned SEL_A0        = 0;
  localparam logic [7:0]  LOCK_YES      = 8'h01;
  localparam logic [7:0]  LOCK_NO       = 8'h00;
  localparam logic [7:0]  SEC_FACTORY   = 8'h99;
  localparam logic [7:0]  SEC_OPEN      = 8'h19;

  typedef enum logic [1:0] {
    PFH_OP_READ,
    PFH_OP_WRITE,
    PFH_OP_CLEAR,
    PFH_OP_AUTOSEL
  } pfh_op_t;

  typedef enum logic [1:0] {
    PFH_PROT_LOCK,
    PFH_PROT_KEEP,
    PFH_PROT_ACCEL
  } pfh_prot_t;

  typedef struct packed {
    pfh_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                word_mode;
  } pfh_req_t;

  typedef struct packed {
    logic clr_n;
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic width_word;
  } pfh_ctl_t;
endpackage

// *** verilog/pfh_host.sv ***
// pfh_host: host-side sequencer driving a parallel nor flash over its pins
// assumes one request at a time via valid/ready; pins synchronous to CLK_SYS
`timescale 1ns/1ps
module pfh_host
  import pfh_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              ARST_N,
  // request side and flash control strobes CTL_OUT
  input  wire logic              REQ_VALID,
  input  wire pfh_req_t          REQ,
  input  wire pfh_prot_t         PROT_MODE,
  input  wire logic              HV_CLEAR,
  output pfh_ctl_t               CTL_OUT,
  output logic                   REQ_READY,
  output logic                   RSP_VALID,
  output logic [DATA_W-1:0]      RSP_DATA,
  output logic                   RSP_LOCKED,
  output logic                   RSP_FACTORY,
  // flash pins
  output logic [ADDR_W-1:0]      FL_ADDR,
  output logic                   FL_AUTOSEL_HV,
  output logic [1:0]             FL_PROTECT_ACCEL,
  output logic                   FL_CLR_HV,
  output logic [DATA_W-1:0]      FL_DQ_O,
  output logic [DATA_W-1:0]      FL_DQ_OE_N,
  input  wire logic [DATA_W-1:0] FL_DQ_I,
  input  wire logic              FL_READY_BUSY
);

  typedef enum logic [2:0] {S_IDLE, S_RD, S_WLO, S_WHI, S_CLR, S_WAITRDY} pfh_st_t;

  pfh_st_t           st_reg, st_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  pfh_req_t          req_reg;
  logic              take;
  logic              cnt_done;
  logic [DATA_W-1:0] rd_word;
  logic              drive_dq;
  logic [DATA_W-1:0] oe_mask;

  assign take     = (st_reg == S_IDLE) && REQ_VALID;
  assign cnt_done = (cnt_reg == '0);
  // byte mode keeps only the low byte
  assign rd_word  = req_reg.word_mode ? FL_DQ_I : {8'h00, FL_DQ_I[7:0]};
  assign drive_dq = (st_next == S_WLO) || (st_next == S_WHI);
  assign oe_mask  = REQ.word_mode ? 16'h0000 : 16'h7F00;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    unique case (st_reg)
      S_IDLE: begin
        if (REQ_VALID) begin
          unique case (REQ.op)
            PFH_OP_WRITE: begin
              st_next  = S_WLO;
              cnt_next = CNT_W'(WE_LOW_CYC);
            end
            PFH_OP_CLEAR: begin
              st_next  = S_CLR;
              cnt_next = CNT_W'(CLR_PULSE_CYC);
            end
            default: begin
              st_next  = S_RD;
              cnt_next = CNT_W'(ACCESS_CYC);
            end
          endcase
        end
      end
      S_RD:      if (cnt_done) st_next = S_IDLE;
      S_WLO: begin
        if (cnt_done) begin
          st_next  = S_WHI;
          cnt_next = CNT_W'(WE_HIGH_CYC);
        end
      end
      S_WHI:     if (cnt_done) st_next = S_IDLE;
      S_CLR:     if (cnt_done) st_next = S_WAITRDY;
      S_WAITRDY: if (FL_READY_BUSY) st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg  <= S_IDLE;
      cnt_reg <= '0;
      req_reg <= '0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      if (take) req_reg <= REQ;
    end
  end

  // pin outputs, all registered
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      // clear held while host in reset
      CTL_OUT          <= '{clr_n: 1'b0, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, width_word: 1'b1};
      REQ_READY        <= 1'b0;
      RSP_VALID        <= 1'b0;
      RSP_DATA         <= '0;
      RSP_LOCKED       <= 1'b0;
      RSP_FACTORY      <= 1'b0;
      FL_ADDR          <= '0;
      FL_AUTOSEL_HV    <= 1'b0;
      FL_PROTECT_ACCEL <= 2'h0;
      FL_CLR_HV        <= 1'b0;
      FL_DQ_O          <= '0;
      FL_DQ_OE_N       <= '1;
    end else begin
      FL_PROTECT_ACCEL <= PROT_MODE;
      FL_CLR_HV        <= HV_CLEAR;
      REQ_READY        <= (st_next == S_IDLE);
      RSP_VALID        <= 1'b0;
      CTL_OUT.clr_n    <= (st_next != S_CLR);
      CTL_OUT.sel_n    <= (st_next == S_IDLE) || (st_next == S_CLR) || (st_next == S_WAITRDY);
      CTL_OUT.oe_n     <= (st_next != S_RD);
      CTL_OUT.we_n     <= (st_next != S_WLO);
      if (take) begin
        CTL_OUT.width_word <= REQ.word_mode;
        FL_ADDR            <= REQ.addr;
        FL_AUTOSEL_HV      <= (REQ.op == PFH_OP_AUTOSEL);
        FL_DQ_O            <= REQ.word_mode ? REQ.wdata : {REQ.addr[0], 7'h00, REQ.wdata[7:0]};
      end
      FL_DQ_OE_N <= drive_dq ? (take ? oe_mask : FL_DQ_OE_N) : (req_reg.word_mode ? '1 : 16'h7FFF);
      if (st_reg == S_RD && cnt_done) begin
        RSP_VALID   <= 1'b1;
        RSP_DATA    <= rd_word;
        RSP_LOCKED  <= (FL_DQ_I[7:0] == LOCK_YES);
        RSP_FACTORY <= (FL_DQ_I[7:0] == SEC_FACTORY);
      end
      if (st_reg == S_WAITRDY && FL_READY_BUSY) RSP_VALID <= 1'b1;
    end
  end

  // read is the first access after clear
  // host forwards only caller-given command data

  a_clear_pulse_len: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $fell(CTL_OUT.clr_n) |-> !CTL_OUT.clr_n [*2]) else $error("clear pulse short");
  a_busy_holds: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == S_WAITRDY && !FL_READY_BUSY) |=> st_reg == S_WAITRDY) else $error("left busy wait");
  a_read_strobes: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CTL_OUT.oe_n |-> !CTL_OUT.sel_n && CTL_OUT.we_n) else $error("bad read strobes");
  a_write_drive: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CTL_OUT.we_n |-> CTL_OUT.oe_n && !CTL_OUT.sel_n && !FL_DQ_OE_N[0]) else $error("bad write");
  a_no_contention: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CTL_OUT.oe_n |-> &FL_DQ_OE_N[14:0]) else $error("data contention");
  sequence s_we_low;
    !CTL_OUT.we_n [*2];
  endsequence
  a_we_pulse: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $fell(CTL_OUT.we_n) |-> s_we_low) else $error("strobe pulse short");
  a_clear_then_wait: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $rose(CTL_OUT.clr_n) && $past(st_reg) == S_CLR |-> st_reg == S_WAITRDY)
    else $error("clear end state");
  a_byte_float: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CTL_OUT.width_word |-> &FL_DQ_OE_N[14:8]) else $error("middle lines driven");
endmodule
